// ---- src/dup_defs.svh ----
/*
  Constants shared by both ends of the dual UART host port link.
  Assumes inclusion by bare name; definitions only.
*/
// Notes on behaviour
// - One 8-bit bus carries address and data
// - Strobe low: address phase, address latched
// - Strobe high: data phase, bytes move
// - Chip select gates transfers; bit 6 picks channel
// - Read strobe fall drives addressed register byte
// - Write strobe rise stores bus byte
// - Low carrier detect means carrier present
// - Clear-to-send shown in modem state bit 4
// - Data-set-ready shown in modem state bit 5
// - Terminal ready low when control bit 0 set
// - Interrupt pin enabled by control bit 3
// - User output low when control bit 3 set
// - Software uses bit 3 for one function only
// - Power-down isolates host port at once; the device does so three core clocks after the pin rises
// - Power-down release resets all registers
// - Master reset clears registers, disables data paths
// - Low ring is ring; rising ring interrupts
// - Request-to-send low when control bit 1 set
// - 128-byte transmit and receive buffers per channel
`ifndef DUP_DEFS_SVH
`define DUP_DEFS_SVH

// ==========================================================
// Device register indices (latched address bits 3..1)
`define DUP_REG_DATA        3'h0
`define DUP_REG_MODEM_CTRL  3'h4
`define DUP_REG_LINE_STATE  3'h5
`define DUP_REG_MODEM_STATE 3'h6
`define DUP_REG_SCRATCH     3'h7
`define DUP_ADDR_CHAN_BIT   6
`define DUP_ADDR_OFF_BIT    7
`define DUP_MC_TERM_BIT     0
`define DUP_MC_REQ_BIT      1
`define DUP_MC_OUT_BIT      3
`define DUP_MC_RST          8'h00
`define DUP_BUFFER_DEPTH    128
`define DUP_RX_ERR_W        3

// ==========================================================
// Host controller Wishbone offsets and fields
`define DUP_WB_ADDR         8'h00
`define DUP_WB_WDATA        8'h04
`define DUP_WB_CTRL         8'h08
`define DUP_WB_STATUS       8'h0C
`define DUP_WB_RDATA        8'h10
`define DUP_CTRL_START_BIT  0
`define DUP_CTRL_READ_BIT   1
`define DUP_CTRL_PD_BIT     2

// ==========================================================
// Host strobe timing in core clock cycles
`define DUP_ADDR_CYC        4'h4
`define DUP_SETUP_CYC       4'h4
`define DUP_STROBE_CYC      4'hA
`define DUP_HOLD_CYC        4'h5

`endif

// ---- src/dup_pkg.sv ----
/*
  Types shared by both ends of the dual UART host port link.
  Assumes dup_defs.svh holds all numeric constants.
*/
package dup_pkg;

  // ==========================================================
  // Host bus cycle sequencer states
  typedef enum logic [2:0]
  {
    DUP_IDLE   = 3'b000,
    DUP_ADDR   = 3'b001,
    DUP_SETUP  = 3'b010,
    DUP_STROBE = 3'b011,
    DUP_HOLD   = 3'b100
  } dup_state_t;

  typedef logic [7:0] dup_byte_t;

endpackage

// ---- src/dup_if.sv ----
/*
  Pin bundle between the host controller and the dual UART device.
  Assumes a pull-up on the shared bus and pull-downs on interrupt pins.
*/
`timescale 1ns/100ps
interface dup_if;
  import dup_pkg::*;

  // ==========================================================
  // Shared address/data bus, each end with its own drive
  dup_byte_t  ad_h;
  logic       ad_h_oe;
  dup_byte_t  ad_d;
  logic       ad_d_oe;
  dup_byte_t  ad;
  // Strobes from the host
  logic       address_latch_strobe_n;
  logic       cs_n;
  logic       read_strobe_n;
  logic       write_strobe_n;
  logic       power_down_pin;
  // Channel interrupt pins, index 0 is channel A
  logic [1:0] irq_out;
  logic [1:0] irq_oe;
  logic [1:0] irq_pin;

  // Wire level resolution; idle bus floats high
  assign ad      = ad_d_oe ? ad_d : (ad_h_oe ? ad_h : 8'hFF);
  assign irq_pin = irq_out & irq_oe;

  modport device (
    input  ad, address_latch_strobe_n, cs_n, read_strobe_n, write_strobe_n, power_down_pin,
    output ad_d, ad_d_oe, irq_out, irq_oe
  );

  modport host (
    input  ad, irq_pin,
    output ad_h, ad_h_oe, address_latch_strobe_n, cs_n, read_strobe_n, write_strobe_n, power_down_pin
  );
endinterface

// ---- src/dup_device.sv ----
/*
  Dual UART device end: multiplexed host port, per-channel modem
  control and status, transmit and receive buffers, power-down.
  Assumes the host meets strobe widths of several core clocks; all
  pins are synchronised here. Serial framing lies outside this block.
*/
// The implementer's own choices: the Wishbone register port and the address map.
`timescale 1ns/100ps
`include "dup_defs.svh"
module dup_device
  import dup_pkg::*;
#(
  parameter int DEPTH = `DUP_BUFFER_DEPTH
)
(
  // Clock and reset
  input  wire logic                     CORE_CLK_I,
  input  wire logic                     RST_N_I,
  // Host pins
  dup_if.device                         HOST,
  // Modem inputs, active low, index 0 is channel A
  input  wire logic [1:0]               CARRIER_DETECT_N_I,
  input  wire logic [1:0]               CLEAR_SEND_N_I,
  input  wire logic [1:0]               SET_READY_N_I,
  input  wire logic [1:0]               RING_INDICATOR_N_I,
  // Modem outputs, active low
  output logic      [1:0]               TERMINAL_READY_N_O,
  output logic      [1:0]               REQUEST_SEND_N_O,
  output logic      [1:0]               USER_OUT_N_O,
  // Transmit buffer drain
  output logic      [1:0][7:0]          TX_DATA_O,
  output logic      [1:0]               TX_VALID_O,
  input  wire logic [1:0]               TX_READY_I,
  // Receive buffer fill, with error flags
  input  wire logic [1:0][7:0]          RX_DATA_I,
  input  wire logic [1:0][2:0]          RX_ERR_I,
  input  wire logic [1:0]               RX_VALID_I,
  output logic      [1:0]               RX_READY_O
);

  localparam int AW = $clog2(DEPTH);
  localparam int EW = 8 + `DUP_RX_ERR_W;

  // ==========================================================
  // Pin synchronisers: two flops before any logic
  logic [20:0] sync1;
  logic [20:0] sync2;
  logic        pd_q;
  logic        rd_q;
  logic        wr_q;
  wire  [20:0] pins = {HOST.power_down_pin, HOST.address_latch_strobe_n, HOST.cs_n,
                       HOST.read_strobe_n, HOST.write_strobe_n, HOST.ad,
                       CARRIER_DETECT_N_I, CLEAR_SEND_N_I, SET_READY_N_I, RING_INDICATOR_N_I};

  always_ff @(posedge CORE_CLK_I)
  begin
    sync1 <= pins;
    sync2 <= sync1;
    pd_q  <= sync2[20];
    rd_q  <= sync2[17];
    wr_q  <= sync2[16];
  end

  // Decoded pin levels and events
  wire       pd_s     = sync2[20];
  wire       ale_n_s  = sync2[19];
  wire       cs_n_s   = sync2[18];
  wire       rd_n_s   = sync2[17];
  wire       wr_n_s   = sync2[16];
  wire [7:0] bus_s    = sync2[15:8];
  wire [1:0] cd_n_s   = sync2[7:6];
  wire [1:0] cts_n_s  = sync2[5:4];
  wire [1:0] dsr_n_s  = sync2[3:2];
  wire [1:0] ri_n_s   = sync2[1:0];
  wire       pd_fall  = pd_q & ~pd_s;
  wire       rst      = ~RST_N_I | pd_fall;
  wire       live     = ~pd_s;

  // ==========================================================
  // Address latch and access decode
  logic [7:0] addr_q;
  wire        sel     = live & ~cs_n_s & ale_n_s & ~addr_q[`DUP_ADDR_OFF_BIT];
  wire        chan    = addr_q[`DUP_ADDR_CHAN_BIT];
  wire [2:0]  idx     = addr_q[3:1];
  wire        rd_fall = sel & rd_q & ~rd_n_s;
  wire        wr_rise = sel & ~wr_q & wr_n_s;
  wire [7:0]  rd_word [0:1];

  // Address phase loads the latch while the strobe is low
  always_ff @(posedge CORE_CLK_I)
  begin
    if (rst)
      addr_q <= 8'h00;
    else if (live & ~ale_n_s)
      addr_q <= bus_s;
  end

  // Bus drive only during a selected read data phase
  always_ff @(posedge CORE_CLK_I)
  begin
    if (rst)
    begin
      HOST.ad_d    <= 8'h00;
      HOST.ad_d_oe <= 1'b0;
    end
    else
    begin
      if (rd_fall)
        HOST.ad_d <= rd_word[chan];
      HOST.ad_d_oe <= sel & ~rd_n_s;
    end
  end

  // ==========================================================
  // Per-channel registers and buffers
  for (genvar c = 0; c < 2; c++)
  begin : g_chan
    logic [7:0]    mc;
    logic [7:0]    scratch;
    logic [3:0]    delta;
    logic [3:0]    prev;
    logic [7:0]    tx_mem [DEPTH];
    logic [EW-1:0] rx_mem [DEPTH];
    logic [AW-1:0] tx_wp;
    logic [AW-1:0] tx_rp;
    logic [AW:0]   tx_cnt;
    logic [AW-1:0] rx_wp;
    logic [AW-1:0] rx_rp;
    logic [AW:0]   rx_cnt;

    wire       me      = (chan == 1'(c));
    wire       wr_here = wr_rise & me;
    wire       rd_here = rd_fall & me;
    wire [3:0] lines   = {cd_n_s[c], ri_n_s[c], dsr_n_s[c], cts_n_s[c]};
    // Deltas: cts, dsr, ring going high, carrier
    wire [3:0] events  = {lines[3] ^ prev[3], lines[2] & ~prev[2],
                          lines[1] ^ prev[1], lines[0] ^ prev[0]};
    wire       tx_full  = (tx_cnt == DEPTH[AW:0]);
    wire       tx_push  = wr_here & (idx == `DUP_REG_DATA) & ~tx_full;
    wire       tx_pop   = (tx_cnt != '0) & (~TX_VALID_O[c] | TX_READY_I[c]);
    wire       rx_empty = (rx_cnt == '0);
    wire       rx_push  = RX_VALID_I[c] & RX_READY_O[c];
    wire       rx_pop   = rd_here & (idx == `DUP_REG_DATA) & ~rx_empty;
    wire [AW:0] next_rx_cnt = rx_cnt + {{AW{1'b0}}, rx_push} - {{AW{1'b0}}, rx_pop};
    wire [EW-1:0] rx_head = rx_mem[rx_rp];
    // Modem state: carrier, ring, ready, clear to send (inverted pins), deltas
    wire [7:0] modem_state = {~lines, delta};
    wire [7:0] line_state  = {1'b0, (tx_cnt == '0), ~tx_full, rx_head[EW-1:8], 1'b0, ~rx_empty};

    // Read selection for this channel
    assign rd_word[c] = (idx == `DUP_REG_DATA)        ? rx_head[7:0] :
                        (idx == `DUP_REG_MODEM_CTRL)  ? mc :
                        (idx == `DUP_REG_LINE_STATE)  ? line_state :
                        (idx == `DUP_REG_MODEM_STATE) ? modem_state :
                        (idx == `DUP_REG_SCRATCH)     ? scratch : 8'h00;

    // Control registers and modem status deltas; an event beats the read clear
    always_ff @(posedge CORE_CLK_I)
    begin
      prev <= lines;
      if (rst)
      begin
        mc      <= `DUP_MC_RST;
        scratch <= 8'h00;
        delta   <= 4'h0;
      end
      else
      begin
        if (wr_here & (idx == `DUP_REG_MODEM_CTRL))
          mc <= bus_s;
        if (wr_here & (idx == `DUP_REG_SCRATCH))
          scratch <= bus_s;
        if (rd_here & (idx == `DUP_REG_MODEM_STATE))
          delta <= events;
        else
          delta <= delta | events;
      end
    end

    // Modem and interrupt pins, all registered
    always_ff @(posedge CORE_CLK_I)
    begin
      if (rst)
      begin
        TERMINAL_READY_N_O[c] <= 1'b1;
        REQUEST_SEND_N_O[c]   <= 1'b1;
        USER_OUT_N_O[c]       <= 1'b1;
        HOST.irq_out[c]       <= 1'b0;
        HOST.irq_oe[c]        <= 1'b0;
      end
      else
      begin
        TERMINAL_READY_N_O[c] <= ~mc[`DUP_MC_TERM_BIT];
        REQUEST_SEND_N_O[c]   <= ~mc[`DUP_MC_REQ_BIT];
        USER_OUT_N_O[c]       <= ~mc[`DUP_MC_OUT_BIT];
        HOST.irq_out[c]       <= |delta;
        HOST.irq_oe[c]        <= mc[`DUP_MC_OUT_BIT] & live;
      end
    end

    // Transmit buffer with a registered output stage
    always_ff @(posedge CORE_CLK_I)
    begin
      if (tx_push)
        tx_mem[tx_wp] <= bus_s;
      if (rst)
      begin
        tx_wp         <= '0;
        tx_rp         <= '0;
        tx_cnt        <= '0;
        TX_VALID_O[c] <= 1'b0;
        TX_DATA_O[c]  <= 8'h00;
      end
      else
      begin
        tx_wp  <= tx_wp + AW'(tx_push);
        tx_rp  <= tx_rp + AW'(tx_pop);
        tx_cnt <= tx_cnt + (AW+1)'(tx_push) - (AW+1)'(tx_pop);
        if (tx_pop)
          TX_DATA_O[c] <= tx_mem[tx_rp];
        if (tx_pop)
          TX_VALID_O[c] <= 1'b1;
        else if (TX_READY_I[c])
          TX_VALID_O[c] <= 1'b0;
      end
    end

    // Receive buffer holding flags beside each character
    always_ff @(posedge CORE_CLK_I)
    begin
      if (rx_push)
        rx_mem[rx_wp] <= {RX_ERR_I[c], RX_DATA_I[c]};
      if (rst)
      begin
        rx_wp         <= '0;
        rx_rp         <= '0;
        rx_cnt        <= '0;
        RX_READY_O[c] <= 1'b0;
      end
      else
      begin
        rx_wp         <= rx_wp + AW'(rx_push);
        rx_rp         <= rx_rp + AW'(rx_pop);
        rx_cnt        <= next_rx_cnt;
        RX_READY_O[c] <= (next_rx_cnt != DEPTH[AW:0]);
      end
    end
  end

endmodule

// ---- src/dup_host.sv ----
/*
  Host end: a Wishbone classic slave whose registers order single
  address-then-data cycles on the multiplexed port.
  Assumes the device answers reads within the strobe width.
*/
`timescale 1ns/100ps
`include "dup_defs.svh"
module dup_host
  import dup_pkg::*;
(
  // Clock and reset
  input  wire logic        CORE_CLK_I,
  input  wire logic        RST_N_I,
  // Wishbone slave
  input  wire logic        WB_CYC_I,
  input  wire logic        WB_STB_I,
  input  wire logic        WB_WE_I,
  input  wire logic [7:0]  WB_ADR_I,
  input  wire logic [3:0]  WB_SEL_I,
  input  wire logic [31:0] WB_DAT_I,
  output logic      [31:0] WB_DAT_O,
  output logic             WB_ACK_O,
  // Device pins
  dup_if.host              DEV
);

  // ==========================================================
  // Synchronisers for bus and interrupt pins
  logic [9:0]  sync1;
  logic [9:0]  sync2;
  always_ff @(posedge CORE_CLK_I)
  begin
    sync1 <= {DEV.irq_pin, DEV.ad};
    sync2 <= sync1;
  end

  // ==========================================================
  // Registers and decode
  dup_state_t state;
  dup_state_t next_state;
  logic [3:0] cnt;
  dup_byte_t  addr_r;
  dup_byte_t  wdata_r;
  dup_byte_t  rdata_r;
  logic       is_read;
  logic       pd_r;
  wire        busy    = (state != DUP_IDLE);
  wire        req     = WB_CYC_I & WB_STB_I & ~WB_ACK_O;
  wire        wr_req  = req & WB_WE_I & WB_SEL_I[0];
  wire        start   = wr_req & (WB_ADR_I == `DUP_WB_CTRL) & WB_DAT_I[`DUP_CTRL_START_BIT] & ~busy;
  wire        cnt_end = (cnt == 4'h1);
  wire [31:0] rd_mux  = (WB_ADR_I == `DUP_WB_ADDR)   ? {24'h0, addr_r} :
                        (WB_ADR_I == `DUP_WB_WDATA)  ? {24'h0, wdata_r} :
                        (WB_ADR_I == `DUP_WB_CTRL)   ? {29'h0, pd_r, is_read, 1'b0} :
                        (WB_ADR_I == `DUP_WB_STATUS) ? {29'h0, sync2[9:8], busy} :
                        (WB_ADR_I == `DUP_WB_RDATA)  ? {24'h0, rdata_r} : 32'h0;

  // Wishbone answer one cycle after the request
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0;
    end
    else
    begin
      WB_ACK_O <= req;
      WB_DAT_O <= rd_mux;
    end
  end

  // Software registers
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      addr_r  <= 8'h00;
      wdata_r <= 8'h00;
      is_read <= 1'b0;
      pd_r    <= 1'b0;
    end
    else
    begin
      if (wr_req & (WB_ADR_I == `DUP_WB_ADDR) & ~busy)
        addr_r <= WB_DAT_I[7:0];
      if (wr_req & (WB_ADR_I == `DUP_WB_WDATA) & ~busy)
        wdata_r <= WB_DAT_I[7:0];
      if (wr_req & (WB_ADR_I == `DUP_WB_CTRL))
        pd_r <= WB_DAT_I[`DUP_CTRL_PD_BIT];
      if (start)
        is_read <= WB_DAT_I[`DUP_CTRL_READ_BIT];
    end
  end

  // ==========================================================
  // Bus cycle sequencer
  always_comb
  begin
    next_state = state;
    case (state)
      DUP_IDLE:   next_state = start ? DUP_ADDR : DUP_IDLE;
      DUP_ADDR:   next_state = cnt_end ? DUP_SETUP : DUP_ADDR;
      DUP_SETUP:  next_state = cnt_end ? DUP_STROBE : DUP_SETUP;
      DUP_STROBE: next_state = cnt_end ? DUP_HOLD : DUP_STROBE;
      DUP_HOLD:   next_state = cnt_end ? DUP_IDLE : DUP_HOLD;
      default:    next_state = DUP_IDLE;
    endcase
  end

  // State, counter, pins; every pin comes from a flop
  always_ff @(posedge CORE_CLK_I)
  begin
    if (!RST_N_I)
    begin
      state                      <= DUP_IDLE;
      cnt                        <= 4'h0;
      rdata_r                    <= 8'h00;
      DEV.ad_h                   <= 8'h00;
      DEV.ad_h_oe                <= 1'b0;
      DEV.address_latch_strobe_n <= 1'b1;
      DEV.cs_n                   <= 1'b1;
      DEV.read_strobe_n          <= 1'b1;
      DEV.write_strobe_n         <= 1'b1;
      DEV.power_down_pin         <= 1'b0;
    end
    else
    begin
      state              <= next_state;
      DEV.power_down_pin <= pd_r;
      if (state == DUP_STROBE && cnt_end && is_read)
        rdata_r <= sync2[7:0];
      case (next_state)
        DUP_ADDR:
        begin
          DEV.ad_h                   <= addr_r;
          DEV.ad_h_oe                <= 1'b1;
          DEV.address_latch_strobe_n <= 1'b0;
        end
        DUP_SETUP:
        begin
          DEV.ad_h                   <= wdata_r;
          DEV.ad_h_oe                <= ~is_read;
          DEV.address_latch_strobe_n <= 1'b1;
          DEV.cs_n                   <= 1'b0;
        end
        DUP_STROBE:
        begin
          DEV.read_strobe_n  <= ~is_read;
          DEV.write_strobe_n <= is_read;
        end
        DUP_HOLD:
        begin
          DEV.read_strobe_n  <= 1'b1;
          DEV.write_strobe_n <= 1'b1;
        end
        default:
        begin
          DEV.ad_h_oe <= 1'b0;
          DEV.cs_n    <= 1'b1;
        end
      endcase
      if (next_state != state)
        cnt <= (next_state == DUP_ADDR)   ? `DUP_ADDR_CYC :
               (next_state == DUP_SETUP)  ? `DUP_SETUP_CYC :
               (next_state == DUP_STROBE) ? `DUP_STROBE_CYC :
               (next_state == DUP_HOLD)   ? `DUP_HOLD_CYC : 4'h0;
      else if (cnt != 4'h0)
        cnt <= cnt - 4'h1;
    end
  end

endmodule

// ---- testbench/dup_properties.sv ----
/*
  Concurrent checks on the pin bundle between host and device ends.
  Assumes instantiation beside the interface, one clock, sync reset.
*/
`timescale 1ns/100ps
module dup_properties
  import dup_pkg::*;
(
  // Clock and reset
  input  wire logic       CORE_CLK_I,
  input  wire logic       RST_N_I,
  // Pin bundle
  input  wire dup_byte_t  ad,
  input  wire logic       ad_h_oe,
  input  wire logic       ad_d_oe,
  input  wire logic       address_latch_strobe_n,
  input  wire logic       cs_n,
  input  wire logic       read_strobe_n,
  input  wire logic       write_strobe_n,
  input  wire logic       power_down_pin,
  input  wire logic [1:0] irq_oe,
  input  wire logic [1:0] irq_pin
);
  // ==========================================================
  // Clocking and address capture
  default clocking @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_N_I);

  dup_byte_t lat_q;

  // Mirror of the device address latch
  always_ff @(posedge CORE_CLK_I)
    if (!address_latch_strobe_n)
      lat_q <= ad;

  // ==========================================================
  // Assertions
  bus_owner_a: assert property (
    ad_d_oe |-> !cs_n && !ad_h_oe) else $error("Device drove bus outside a read");
  pd_isolate_a: assert property (
    power_down_pin [*4] |-> !ad_d_oe && irq_oe == 2'h0) else $error("Pins active in power-down");
  pd_release_a: assert property (
    $fell(power_down_pin) |-> (irq_oe == 2'h0) [*6]) else $error("Irq enable kept after wake");
  read_reply_a: assert property (
    $fell(read_strobe_n) && !cs_n && !lat_q[7] && !power_down_pin |-> ##[1:5] ad_d_oe)
    else $error("No read data driven");
  addr_phase_a: assert property (
    !address_latch_strobe_n |-> cs_n && ad_h_oe && read_strobe_n && write_strobe_n)
    else $error("Address phase malformed");
  wr_phase_a: assert property (
    !write_strobe_n |-> ad_h_oe && !cs_n && address_latch_strobe_n) else $error("Write data phase malformed");
  wr_width_a: assert property (
    $fell(write_strobe_n) |-> !write_strobe_n [*8] ##1 !write_strobe_n [*2] ##1 write_strobe_n)
    else $error("Write strobe width wrong");
  rd_phase_a: assert property (
    !read_strobe_n |-> !ad_h_oe && !cs_n && write_strobe_n) else $error("Read data phase malformed");

  // Main scenarios reached
  cover property ($fell(read_strobe_n));
  cover property ($rose(irq_pin[1]));
  cover property ($fell(power_down_pin));
endmodule

// ---- testbench/tb_dual_uart_host_and_modem_pins.sv ----
/*
  Self-checking bench: Wishbone master drives the host end, which runs
  port cycles against the device end. Assumes the design under src/.
*/
`timescale 1ns/100ps
module tb_dual_uart_host_and_modem_pins
  import dup_pkg::*;
;
  // ==========================================================
  // Bench signals
  logic            clk, rst_n, cyc, stb, we, ack, pd;
  logic [7:0]      adr;
  logic [3:0]      sel;
  logic [31:0]     wdat, rdat, r;
  logic [1:0]      cd_n, cts_n, dsr_n, ri_n, tx_ready, rx_valid;
  logic [1:0]      tr_n, rs_n, uo_n, tx_valid, rx_ready;
  logic [1:0][7:0] tx_data, rx_data;
  logic [1:0][2:0] rx_err;
  dup_byte_t       q, v;
  int              num_errors, comparisons, cycles;
  logic [7:0]      mc [4] = '{8'h01, 8'h02, 8'h08, 8'h0B};

  // ==========================================================
  // Both ends joined by the pin bundle
  dup_if u_dup_if ();
  dup_device #(.DEPTH(128)) u_dup_device (.CORE_CLK_I(clk), .RST_N_I(rst_n), .HOST(u_dup_if),
    .CARRIER_DETECT_N_I(cd_n), .CLEAR_SEND_N_I(cts_n), .SET_READY_N_I(dsr_n), .RING_INDICATOR_N_I(ri_n),
    .TERMINAL_READY_N_O(tr_n), .REQUEST_SEND_N_O(rs_n), .USER_OUT_N_O(uo_n), .TX_DATA_O(tx_data),
    .TX_VALID_O(tx_valid), .TX_READY_I(tx_ready), .RX_DATA_I(rx_data), .RX_ERR_I(rx_err),
    .RX_VALID_I(rx_valid), .RX_READY_O(rx_ready));
  dup_host u_dup_host (.CORE_CLK_I(clk), .RST_N_I(rst_n), .WB_CYC_I(cyc), .WB_STB_I(stb), .WB_WE_I(we),
    .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .DEV(u_dup_if));
  dup_properties u_dup_properties (.CORE_CLK_I(clk), .RST_N_I(rst_n), .ad(u_dup_if.ad),
    .ad_h_oe(u_dup_if.ad_h_oe), .ad_d_oe(u_dup_if.ad_d_oe), .cs_n(u_dup_if.cs_n),
    .address_latch_strobe_n(u_dup_if.address_latch_strobe_n), .read_strobe_n(u_dup_if.read_strobe_n),
    .write_strobe_n(u_dup_if.write_strobe_n), .power_down_pin(u_dup_if.power_down_pin),
    .irq_oe(u_dup_if.irq_oe), .irq_pin(u_dup_if.irq_pin));

  // Clock, 20 ns period
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      num_errors++;
      print_verdict();
    end
  end

  // ==========================================================
  // Tasks
  task print_verdict();
    $display("Mismatches %0d, comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Classic single cycle, held until ack is sampled
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] o);
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    sel  <= 4'h1;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    o = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sel <= 4'h0;
  endtask

  // One port cycle: address, data, start, poll busy, fetch
  task dev(input logic rd, input logic [7:0] a, input logic [7:0] d, output logic [7:0] o);
    logic [31:0] t;
    wb(1'b1, 8'h00, {24'h0, a}, t);
    wb(1'b1, 8'h04, {24'h0, d}, t);
    wb(1'b1, 8'h08, {29'h0, pd, rd, 1'b1}, t);
    do wb(1'b0, 8'h0C, 32'h0, t); while (t[0] !== 1'b0);
    wb(1'b0, 8'h10, 32'h0, t);
    o = t[7:0];
  endtask

  // ==========================================================
  // Main sequence
  initial
  begin
    {rst_n, cyc, stb, we, pd, adr, sel, wdat, tx_ready, rx_valid} = '0;
    {cd_n, cts_n, dsr_n, ri_n} = 8'hFF;
    rx_data = '0;
    rx_err = '0;
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    chk({2'h0, tr_n, rs_n, uo_n}, 8'h3F);
    chk({6'h0, u_dup_if.irq_pin}, 8'h00);
    chk({6'h0, rx_ready}, 8'h03);
    // Scratch per channel, then an address with bit 7 set
    dev(1'b0, 8'h0E, 8'hA5, q);
    dev(1'b0, 8'h4E, 8'h5A, q);
    dev(1'b1, 8'h0E, 8'h00, q);
    chk(q, 8'hA5);
    dev(1'b1, 8'h4E, 8'h00, q);
    chk(q, 8'h5A);
    dev(1'b1, 8'h8E, 8'h00, q);
    chk(q, 8'hFF);
    // Modem control codes on both channels
    for (int i = 0; i < 8; i++)
    begin
      v = mc[i % 4];
      dev(1'b0, {1'b0, i[2], 6'h08}, v, q);
      repeat (4) @(posedge clk);
      chk({7'h0, tr_n[i / 4]}, {7'h0, ~v[0]});
      chk({7'h0, rs_n[i / 4]}, {7'h0, ~v[1]});
      chk({7'h0, uo_n[i / 4]}, {7'h0, ~v[3]});
      chk({7'h0, u_dup_if.irq_oe[i / 4]}, {7'h0, v[3]});
    end
    // Modem inputs reflected in the state register
    cts_n <= 2'b10;
    dsr_n <= 2'b01;
    cd_n  <= 2'b10;
    ri_n  <= 2'b01;
    repeat (6) @(posedge clk);
    dev(1'b1, 8'h0C, 8'h00, q);
    chk({4'h0, q[7:4]}, 8'h09);
    dev(1'b1, 8'h4C, 8'h00, q);
    chk({4'h0, q[7:4]}, 8'h06);
    chk({7'h0, u_dup_if.irq_pin[1]}, 8'h00);
    // Ring line going high raises channel B interrupt
    ri_n <= 2'b11;
    repeat (6) @(posedge clk);
    chk({7'h0, u_dup_if.irq_pin[1]}, 8'h01);
    wb(1'b0, 8'h0C, 32'h0, r);
    chk({7'h0, r[2]}, 8'h01);
    dev(1'b1, 8'h4C, 8'h00, q);
    chk({4'h0, q[3:0]}, 8'h04);
    chk({7'h0, u_dup_if.irq_pin[1]}, 8'h00);
    // Transmit push with a stalled drain, then one handshake
    dev(1'b0, 8'h00, 8'h5C, q);
    repeat (3) @(posedge clk);
    chk({tx_valid[0], tx_data[0][6:0]}, 8'hDC);
    tx_ready <= 2'b01;
    @(posedge clk);
    tx_ready <= 2'b00;
    repeat (2) @(posedge clk);
    chk({7'h0, tx_valid[0]}, 8'h00);
    // Receive one byte with error flags on channel B, check line state, read it back
    rx_data[1] <= 8'h77;
    rx_err[1]  <= 3'h5;
    rx_valid   <= 2'b10;
    @(posedge clk);
    rx_valid   <= 2'b00;
    dev(1'b1, 8'h4A, 8'h00, q);
    chk(q, 8'h75);
    dev(1'b1, 8'h40, 8'h00, q);
    chk(q, 8'h77);
    // Power-down isolates, release resets registers
    pd = 1'b1;
    wb(1'b1, 8'h08, 32'h4, r);
    repeat (6) @(posedge clk);
    chk({6'h0, u_dup_if.irq_pin}, 8'h00);
    dev(1'b1, 8'h0E, 8'h00, q);
    chk(q, 8'hFF);
    pd = 1'b0;
    wb(1'b1, 8'h08, 32'h0, r);
    repeat (8) @(posedge clk);
    chk({2'h0, tr_n, rs_n, uo_n}, 8'h3F);
    dev(1'b1, 8'h08, 8'h00, q);
    chk(q, 8'h00);
    print_verdict();
  end
endmodule
